// >>> src/msq_sequencer.sv
`timescale 1ns/1ns
module msq_sequencer
   import msq_pkg::*;
#(
   parameter logic [15:0] TICK_LEN = 16'(TICK_CYC)
) (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       quick_boot,
   input  wire logic       update_mode,
   input  wire logic [1:0] update_rate,
   input  wire logic [1:0] cap_res,
   input  wire logic [1:0] temp_res,
   input  wire logic       enter_command_cmd,
   input  wire logic       leave_command_cmd,
   input  wire logic       measure_request_cmd,
   input  wire logic       data_fetched,
   output logic            i2c_forced,
   output logic            cmd_state,
   output logic            wake_phase,
   output logic            temp_conv,
   output logic            temp_calc,
   output logic            cap_conv,
   output logic            cap_calc,
   output logic            result_load,
   output logic            powered_down,
   output logic [1:0]      status_bits
);

   msq_state_t  state_r, state_nxt;
   logic        temp_due_r, temp_due_nxt;
   logic [2:0]  tcnt_r, tcnt_nxt;
   logic [1:0]  status_r, status_nxt;
   logic        tmr_load;
   logic [15:0] tmr_ticks;
   logic        tmr_exp;
   logic        i2c_r, cmd_r, wake_r, tconv_r, tcalc_r, cconv_r, ccalc_r;
   logic        load_r, pd_r;
   logic [31:0] dwell_r, dwell_nxt;
   logic [15:0] ticks_r, ticks_nxt;

   // one shared time base for window, phases and power-down
   msq_timer #(
      .TICK_LEN (TICK_LEN)
   ) u_timer (
      .mclk       (mclk),
      .rst_n      (rst_n),
      .load       (tmr_load),
      .load_ticks (tmr_ticks),
      .expired    (tmr_exp)
   ); // see (RULE20)

   always_comb begin
      state_nxt    = state_r;
      temp_due_nxt = temp_due_r;
      tcnt_nxt     = tcnt_r;
      case (state_r)
         S_BOOT:   state_nxt = S_WINDOW;
         S_WINDOW: begin
            if (enter_command_cmd) begin
               state_nxt = S_CMD; // see (RULE3)
            end else if (tmr_exp) begin
               state_nxt    = S_WAKE; // see (RULE4)
               temp_due_nxt = 1'b1;
            end
         end
         S_CMD: begin
            if (leave_command_cmd) begin
               state_nxt    = S_WAKE; // see (RULE4)
               temp_due_nxt = 1'b1;
               tcnt_nxt     = 3'h0;
            end
         end
         S_WAKE: begin
            if (tmr_exp) begin
               // see (RULE6) (RULE9)
               state_nxt = temp_due_r ? S_TCONV : S_CCONV;
            end
         end
         S_TCONV:  if (tmr_exp) state_nxt = S_TCALC;
         S_TCALC:  if (tmr_exp) state_nxt = S_CCONV;
         S_CCONV:  if (tmr_exp) state_nxt = S_CCALC;
         S_CCALC:  if (tmr_exp) state_nxt = S_REFRESH; // see (RULE5)
         S_REFRESH: begin
            // see (RULE22)
            tcnt_nxt = temp_due_r ? 3'h0 : tcnt_r + 3'h1;
            if (update_mode) begin
               temp_due_nxt = (tcnt_nxt == TEMP_LAST); // see (RULE14)
               // see (RULE10) (RULE13)
               state_nxt = (update_rate == 2'h0) ? S_WAKE : S_PDOWN;
            end else begin
               temp_due_nxt = 1'b1;
               state_nxt    = S_SLEEP;
            end
         end
         S_PDOWN:  if (tmr_exp) state_nxt = S_WAKE; // see (RULE13)
         S_SLEEP: begin
            if (measure_request_cmd) begin
               state_nxt = S_WAKE; // see (RULE18)
            end
         end
         default:  state_nxt = S_BOOT;
      endcase
   end

   // duration of the phase being entered
   always_comb begin
      tmr_load  = (state_nxt != state_r);
      tmr_ticks = 16'h0001;
      case (state_nxt)
         S_WINDOW: tmr_ticks = quick_boot ? WIN_FAST_TK : WIN_SLOW_TK; // see (RULE2)
         S_WAKE:   tmr_ticks = WAKE_TK; // see (RULE15)
         S_TCONV:  tmr_ticks = conv_ticks(temp_res); // see (RULE7) (RULE8) (RULE16)
         S_TCALC:  tmr_ticks = TCALC_TK; // see (RULE16)
         S_CCONV:  tmr_ticks = conv_ticks(cap_res); // see (RULE7) (RULE8)
         S_CCALC:  tmr_ticks = CCALC_TK; // see (RULE15)
         S_PDOWN:  tmr_ticks = pdown_ticks(update_rate); // see (RULE11)
         default:  tmr_load  = 1'b0;
      endcase
   end

   // fresh result beats a fetch that lands in the same cycle
   always_comb begin
      status_nxt = status_r;
      if (state_nxt == S_CMD) begin
         status_nxt = ST_CMD; // see (RULE21)
      end else if (state_nxt == S_REFRESH) begin
         status_nxt = ST_FRESH; // see (RULE21)
      end else if (data_fetched && status_r == ST_FRESH) begin
         status_nxt = ST_STALE; // see (RULE21)
      end else if (status_r == ST_CMD && state_nxt != S_CMD) begin
         status_nxt = ST_STALE;
      end
   end

   // assertion helper: cycles spent in the present state, ticks loaded on entry
   always_comb begin
      dwell_nxt = dwell_r + 32'h00000001;
      ticks_nxt = ticks_r;
      if (state_nxt != state_r) begin
         dwell_nxt = 32'h00000000;
      end
      if (tmr_load) begin
         ticks_nxt = tmr_ticks;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         dwell_r <= 32'h00000000;
         ticks_r <= 16'h0000;
      end else begin
         dwell_r <= dwell_nxt;
         ticks_r <= ticks_nxt;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_r    <= S_BOOT;
         temp_due_r <= 1'b1;
         tcnt_r     <= 3'h0;
         status_r   <= ST_RESET;
         i2c_r      <= 1'b1;
         cmd_r      <= 1'b0;
         wake_r     <= 1'b0;
         tconv_r    <= 1'b0;
         tcalc_r    <= 1'b0;
         cconv_r    <= 1'b0;
         ccalc_r    <= 1'b0;
         load_r     <= 1'b0;
         pd_r       <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         temp_due_r <= temp_due_nxt;
         tcnt_r     <= tcnt_nxt;
         status_r   <= status_nxt;
         // see (RULE1)
         i2c_r      <= (state_nxt == S_BOOT) || (state_nxt == S_WINDOW) ||
                       (state_nxt == S_CMD);
         cmd_r      <= (state_nxt == S_CMD);
         wake_r     <= (state_nxt == S_WAKE);
         tconv_r    <= (state_nxt == S_TCONV);
         tcalc_r    <= (state_nxt == S_TCALC);
         cconv_r    <= (state_nxt == S_CCONV);
         ccalc_r    <= (state_nxt == S_CCALC);
         // see (RULE12) (RULE19)
         load_r     <= (state_nxt == S_REFRESH);
         pd_r       <= (state_nxt == S_PDOWN) || (state_nxt == S_SLEEP);
      end
   end

   assign i2c_forced   = i2c_r;
   assign cmd_state    = cmd_r;
   assign wake_phase   = wake_r;
   assign temp_conv    = tconv_r;
   assign temp_calc    = tcalc_r;
   assign cap_conv     = cconv_r;
   assign cap_calc     = ccalc_r;
   assign result_load  = load_r;
   assign powered_down = pd_r;
   assign status_bits  = status_r;

   i2c_in_window_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE1)
      state_r == S_WINDOW |-> i2c_forced)
      else $error("slave not forced to i2c in window");

   window_len_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE2)
      (state_r == S_WINDOW && !enter_command_cmd && !tmr_exp) |=> state_r == S_WINDOW)
      else $error("command window closed too early");

   boot_window_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE2)
      (state_r == S_BOOT) |=> state_r == S_WINDOW && i2c_forced)
      else $error("window not opened after reset");

   cmd_entry_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE3)
      (state_r == S_WINDOW && enter_command_cmd) |=> cmd_state ##1 cmd_state)
      else $error("enter command not honoured");

   cmd_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE3)
      (state_r == S_CMD && !leave_command_cmd) |=> state_r == S_CMD)
      else $error("command state left by itself");

   leave_cycle_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE4)
      (state_r == S_CMD && leave_command_cmd) |=> wake_phase && temp_due_r)
      else $error("leave command did not start full cycle");

   cap_order_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE6)
      $rose(cap_conv) |-> $past(state_r, 2) == S_TCALC || $past(state_r, 2) == S_WAKE)
      else $error("capacitance conversion out of order");

   result_after_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE5)
      $rose(result_load) |-> $past(cap_calc) ##1 !result_load)
      else $error("result load not after capacitance calc");

   status_fresh_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE21)
      result_load |-> status_bits == ST_FRESH)
      else $error("status not fresh after refresh");

   status_cmd_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE21)
      cmd_state |-> status_bits == ST_CMD)
      else $error("status not command in command state");

   temp_count_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE22)
      tcnt_r <= TEMP_LAST)
      else $error("temperature counter overran");

   back_to_back_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE13)
      (result_load && update_mode && update_rate == 2'h0) |=> wake_phase && !powered_down)
      else $error("zero interval did not restart at once");

   pdown_entry_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE12)
      $rose(powered_down) |-> $past(result_load))
      else $error("power-down entered without refresh");

   sleep_idle_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE18)
      (state_r == S_SLEEP && !measure_request_cmd) |=> state_r == S_SLEEP)
      else $error("sleep mode measured without request");

   phase_time_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE15) (RULE20)
      (tmr_exp && state_r != S_CMD) |-> dwell_r == 32'(ticks_r) * 32'(TICK_LEN))
      else $error("phase length differs from loaded ticks");

   phase_onehot_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE6)
      $onehot0({wake_phase, temp_conv, temp_calc, cap_conv, cap_calc,
                result_load, powered_down}))
      else $error("more than one phase output active");

   temp_first_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE6)
      (state_r == S_WAKE && tmr_exp && temp_due_r) |=> temp_conv)
      else $error("temperature not first after wake-up");

   temp_skip_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE9)
      (state_r == S_WAKE && tmr_exp && !temp_due_r) |=> cap_conv)
      else $error("temperature not skipped");

   temp_then_cap_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE14)
      (state_r == S_TCALC && tmr_exp) |=> cap_conv)
      else $error("capacitance not directly after temperature");

   cmd_i2c_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE1)
      cmd_state |-> i2c_forced)
      else $error("slave not forced to i2c in command state");

   leave_mode_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE4)
      $fell(i2c_forced) |-> wake_phase)
      else $error("programmed mode without measurement cycle");

   sleep_wake_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE18)
      (state_r == S_SLEEP && measure_request_cmd) |=> wake_phase && !powered_down)
      else $error("measurement request not honoured");

   rate_pdown_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE11)
      (result_load && update_mode && update_rate != 2'h0) |=> powered_down && state_r == S_PDOWN)
      else $error("update interval without power-down");

   sleep_entry_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE10)
      (result_load && !update_mode) |=> powered_down && state_r == S_SLEEP)
      else $error("sleep mode did not wait for request");

   status_leave_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE21)
      $fell(cmd_state) |-> status_bits == ST_STALE)
      else $error("status not stale after command state");

   refresh_once_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE12)
      result_load |=> !result_load)
      else $error("result load longer than one cycle");

endmodule // msq_sequencer

// >>> src/msq_pkg.sv
// Behaviour
// (RULE1) after reset the serial slave answers as I2C during the command window
// (RULE2) command window lasts 3 ms with quick boot set, else 10 ms
// (RULE3) enter-command inside the window enters command state, which never exits by itself
// (RULE4) window expiry or leave-command starts programmed mode and one full cycle
// (RULE5) first result written when capacitance correction ends; then mode scheduling
// (RULE6) cycle order: wake-up, temperature conversion and calc, capacitance conversion and calc
// (RULE7) resolution code 00/01/10/11 gives 0.30/1.15/4.50/18.0 ms conversion
// (RULE8) capacitance and temperature use separate resolution fields
// (RULE9) update mode skips temperature on most cycles: wake-up plus capacitance only
// (RULE10) one bit selects update mode (periodic) or sleep mode (on request)
// (RULE11) update interval code 00/01/10/11 gives 0/5/25/125 ms power-down
// (RULE12) cycle end refreshes output register, density and alarm outputs, then power-down
// (RULE13) power-down expiry starts next cycle; code 00 measures back to back
// (RULE14) update mode: one temperature per six capacitance measurements, same lengthened cycle
// (RULE15) capacitance period is conversion plus 0.1 ms wake plus 0.3 ms calc plus interval
// (RULE16) temperature adds its conversion plus 0.25 ms calc to its cycle
// (RULE17) durations are typical; partner must allow up to 1.1 times typical
// (RULE18) sleep mode measures only on the master's measurement request
// (RULE19) update mode serves every output option
// (RULE20) all timing comes from one free-running time base started at reset release; the timer here restarts on each phase load and stops at expiry
// (RULE21) status reads 00 fresh, 01 already read, 10 in command state
// (RULE22) temperature counter cleared after temperature cycle, advanced after capacitance-only
package msq_pkg;

   localparam int CLK_NS  = 10;
   localparam int TICK_NS = 10000;
   localparam int TICK_CYC = TICK_NS / CLK_NS;

   localparam int WIN_FAST_US = 3000;
   localparam int WIN_SLOW_US = 10000;
   localparam int WAKE_US     = 100;
   localparam int TCALC_US    = 250;
   localparam int CCALC_US    = 300;
   localparam int CONV0_US    = 300;
   localparam int CONV1_US    = 1150;
   localparam int CONV2_US    = 4500;
   localparam int CONV3_US    = 18000;
   localparam int PD1_US      = 5000;
   localparam int PD2_US      = 25000;
   localparam int PD3_US      = 125000;
   localparam int TEMP_EVERY  = 6;

   localparam logic [15:0] WIN_FAST_TK = 16'(WIN_FAST_US * 1000 / TICK_NS);
   localparam logic [15:0] WIN_SLOW_TK = 16'(WIN_SLOW_US * 1000 / TICK_NS);
   localparam logic [15:0] WAKE_TK     = 16'(WAKE_US * 1000 / TICK_NS);
   localparam logic [15:0] TCALC_TK    = 16'(TCALC_US * 1000 / TICK_NS);
   localparam logic [15:0] CCALC_TK    = 16'(CCALC_US * 1000 / TICK_NS);
   localparam logic [15:0] CONV0_TK    = 16'(CONV0_US * 1000 / TICK_NS);
   localparam logic [15:0] CONV1_TK    = 16'(CONV1_US * 1000 / TICK_NS);
   localparam logic [15:0] CONV2_TK    = 16'(CONV2_US * 1000 / TICK_NS);
   localparam logic [15:0] CONV3_TK    = 16'(CONV3_US * 1000 / TICK_NS);
   localparam logic [15:0] PD1_TK      = 16'(PD1_US * 1000 / TICK_NS);
   localparam logic [15:0] PD2_TK      = 16'(PD2_US * 1000 / TICK_NS);
   localparam logic [15:0] PD3_TK      = 16'(PD3_US * 1000 / TICK_NS);
   localparam logic [2:0]  TEMP_LAST   = 3'(TEMP_EVERY - 1);

   localparam logic [1:0] ST_FRESH = 2'h0;
   localparam logic [1:0] ST_STALE = 2'h1;
   localparam logic [1:0] ST_CMD   = 2'h2;
   localparam logic [1:0] ST_RESET = ST_STALE;

   typedef enum logic [3:0] {
      S_BOOT, S_WINDOW, S_CMD, S_WAKE, S_TCONV, S_TCALC,
      S_CCONV, S_CCALC, S_REFRESH, S_PDOWN, S_SLEEP
   } msq_state_t;

   function automatic logic [15:0] conv_ticks(input logic [1:0] res);
      case (res)
         2'h0:    conv_ticks = CONV0_TK;
         2'h1:    conv_ticks = CONV1_TK;
         2'h2:    conv_ticks = CONV2_TK;
         default: conv_ticks = CONV3_TK;
      endcase
   endfunction

   function automatic logic [15:0] pdown_ticks(input logic [1:0] rate);
      case (rate)
         2'h1:    pdown_ticks = PD1_TK;
         2'h2:    pdown_ticks = PD2_TK;
         2'h3:    pdown_ticks = PD3_TK;
         default: pdown_ticks = 16'h0001;
      endcase
   endfunction

endpackage

// >>> src/msq_timer.sv
`timescale 1ns/1ns
module msq_timer
   import msq_pkg::*;
#(
   parameter logic [15:0] TICK_LEN = 16'(TICK_CYC)
) (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        load,
   input  wire logic [15:0] load_ticks,
   output logic             expired
);

   logic [15:0] div_r, div_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic        run_r, run_nxt;
   logic        exp_r, exp_nxt;

   // time base: tick enable every TICK_LEN cycles, counts down in ticks
   // typical counts only, the 1.1 spread is left to the host's margin
   always_comb begin // see (RULE17)
      div_nxt = div_r;
      cnt_nxt = cnt_r;
      run_nxt = run_r;
      exp_nxt = 1'b0;
      if (load) begin
         cnt_nxt = load_ticks;
         div_nxt = 16'h0000;
         run_nxt = 1'b1;
      end else if (run_r) begin
         if (div_r == TICK_LEN - 16'h0001) begin
            div_nxt = 16'h0000;
            if (cnt_r <= 16'h0001) begin
               cnt_nxt = 16'h0000;
               run_nxt = 1'b0;
               exp_nxt = 1'b1;
            end else begin
               cnt_nxt = cnt_r - 16'h0001;
            end
         end else begin
            div_nxt = div_r + 16'h0001;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         div_r <= 16'h0000;
         cnt_r <= 16'h0000;
         run_r <= 1'b0;
         exp_r <= 1'b0;
      end else begin
         div_r <= div_nxt;
         cnt_r <= cnt_nxt;
         run_r <= run_nxt;
         exp_r <= exp_nxt;
      end
   end

   assign expired = exp_r;

endmodule // msq_timer

// >>> bench/msq_host.sv
`timescale 1ns/1ns
module msq_host (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic req_en,
   input  wire logic result_load,
   input  wire logic powered_down,
   output logic      measure_request_cmd = 1'b0,
   output logic      data_fetched = 1'b0
);
   logic [7:0] dly_r = 8'hFF;

   // fetch soon after each refresh, request a new cycle after a long sleep
   always @(posedge mclk) begin
      data_fetched <= 1'b0;
      measure_request_cmd <= 1'b0;
      if (!rst_n || result_load) begin
         dly_r <= 8'h00;
      end else if (dly_r != 8'hFF) begin
         dly_r <= dly_r + 8'h01;
      end
      if (dly_r == 8'h02) begin
         data_fetched <= 1'b1;
      end
      if (req_en && powered_down && dly_r == 8'hC8) begin
         measure_request_cmd <= 1'b1;
      end
   end
endmodule // msq_host

// >>> bench/tb_measurement_sequencer.sv
`timescale 1ns/1ns
module tb_measurement_sequencer;
   localparam int TL = 2;
   logic       mclk = 1'b0;
   logic       rst_n = 1'b0;
   logic       enter_cmd = 1'b0;
   logic       leave_cmd = 1'b0;
   logic       req_en = 1'b0;
   logic [7:0] cfg = 8'h00;
   logic [7:0] cfg_r = 8'h00;
   logic       meas_req, fetched, i2c_forced, cmd_state;
   logic       wake, tconv, tcalc, cconv, ccalc, rload, pdown;
   logic [1:0] status_bits;
   logic [6:0] ph;
   int         bad_count = 0;
   int         num_checks = 0;
   int         tcnt = 0;
   int         ct[4] = '{30, 115, 450, 1800};
   int         pt[4] = '{0, 500, 2500, 12500};

   assign ph = {pdown, rload, ccalc, cconv, tcalc, tconv, wake};
   initial begin
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) cfg_r <= cfg;

   msq_sequencer #(.TICK_LEN(16'(TL))) i_dut (
      .mclk(mclk), .rst_n(rst_n), .quick_boot(cfg_r[7]), .update_mode(cfg_r[6]),
      .update_rate(cfg_r[5:4]), .cap_res(cfg_r[3:2]), .temp_res(cfg_r[1:0]),
      .enter_command_cmd(enter_cmd), .leave_command_cmd(leave_cmd),
      .measure_request_cmd(meas_req), .data_fetched(fetched), .i2c_forced(i2c_forced),
      .cmd_state(cmd_state), .wake_phase(wake), .temp_conv(tconv), .temp_calc(tcalc),
      .cap_conv(cconv), .cap_calc(ccalc), .result_load(rload), .powered_down(pdown),
      .status_bits(status_bits));

   msq_host i_host (
      .mclk(mclk), .rst_n(rst_n), .req_en(req_en), .result_load(rload),
      .powered_down(pdown), .measure_request_cmd(meas_req), .data_fetched(fetched));

   function automatic int ln(input int t);
      return t * TL + 1;
   endfunction

   task automatic tick();
      @(posedge mclk);
      #1;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: saw %0h, expected %0h", $time, got, exp);
      end
   endtask

   // one phase must be alone and last exactly len cycles
   task automatic step(input int idx, input int len);
      int         n;
      logic [6:0] cur;
      n = 0;
      while (ph === 7'h40 && idx != 6 && n < 40000) begin
         tick();
         n++;
      end
      check(32'(ph), 32'(7'h01 << idx));
      cur = ph;
      n = 0;
      while (ph === cur && n < 40000) begin
         tick();
         n++;
      end
      check(32'(n), 32'(len));
   endtask

   task automatic meas();
      logic t;
      t = !cfg[6] || tcnt == 0;
      tcnt = t ? 1 : (tcnt == 5 ? 0 : tcnt + 1);
      step(0, ln(10));
      if (t) begin
         step(1, ln(ct[cfg[1:0]]));
         step(2, ln(25));
      end
      step(3, ln(ct[cfg[3:2]]));
      step(4, ln(30));
      check(32'(status_bits), 32'h0);
      step(5, 1);
      if (cfg[6] && cfg[5:4] != 2'h0) step(6, ln(pt[cfg[5:4]]));
   endtask

   task automatic boot(input logic [7:0] c);
      cfg = c;
      tcnt = 0;
      @(posedge mclk) rst_n <= 1'b0;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      #1;
      check(32'({i2c_forced, status_bits, ph}), 32'h280);
   endtask

   task automatic window(input int w);
      int n;
      n = 0;
      while (i2c_forced === 1'b1 && n < 3000) begin
         tick();
         n++;
      end
      check(32'(n >= ln(w) && n <= ln(w) + 3), 32'h1);
   endtask

   task automatic t_update();
      boot(8'hC1);
      window(300);
      repeat (7) meas();
      for (int r = 1; r < 4; r++) begin
         cfg[5:4] = 2'(r);
         meas();
      end
      cfg[5:4] = 2'h0;
      for (int r = 0; r < 4; r++) begin
         cfg[3:0] = {2'(r), 2'(3 - r)};
         meas();
      end
      $display("update mode test done");
   endtask

   task automatic t_cmd();
      boot(8'h40);
      @(posedge mclk);
      @(posedge mclk) enter_cmd <= 1'b1;
      @(posedge mclk) enter_cmd <= 1'b0;
      #1;
      check(32'({cmd_state, status_bits}), 32'h6);
      repeat (2100) tick();
      check(32'({cmd_state, i2c_forced, ph}), 32'h180);
      @(posedge mclk) leave_cmd <= 1'b1;
      @(posedge mclk) leave_cmd <= 1'b0;
      #1;
      check(32'({cmd_state, i2c_forced, status_bits}), 32'h1);
      meas();
      meas();
      $display("command state test done");
   endtask

   task automatic t_sleep();
      boot(8'h01);
      req_en <= 1'b1;
      window(1000);
      meas();
      repeat (100) tick();
      check(32'(status_bits), 32'h1);
      check(32'(ph), 32'h40);
      meas();
      $display("sleep mode test done");
   endtask

   task automatic results();
      $display("checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      t_update();
      t_cmd();
      t_sleep();
      results();
   end

   // all tests together need roughly half of this span
   initial begin
      repeat (90000) @(posedge mclk);
      bad_count++;
      results();
   end
endmodule // tb_measurement_sequencer
